// ### pkg/pe_status_pkg.sv
// Constants and types for the program/erase status word logic
package pe_status_pkg;
	localparam int STATUS_W      = 8;
	localparam int BIT_READY     = 7;
	localparam int BIT_ERS_SUSP  = 6;
	localparam int BIT_ERS_FAIL  = 5;
	localparam int BIT_PRG_FAIL  = 4;
	localparam int BIT_SUPPLY    = 3;
	localparam int BIT_PRG_SUSP  = 2;
	localparam int BIT_LOCK      = 1;
	localparam int BIT_BANK      = 0;
	localparam logic [7:0] STATUS_RESET = 8'h80;
	localparam int BANK_W_DEF    = 4;
	localparam int DATA_W_DEF    = 16;
	localparam int SYNC_STAGES   = 2;

	typedef enum logic [2:0] {
		ENG_IDLE,
		ENG_RUN,
		ENG_SUSP_WAIT,
		ENG_SUSPENDED
	} engine_state_t;

	typedef enum logic [1:0] {
		OP_NONE,
		OP_PROGRAM,
		OP_ERASE
	} op_kind_t;
endpackage

// ### verilog/pin_sync.sv
// Two-stage synchroniser for a bundle of pin levels
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             ref_clk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	// First stage feeds only the second
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ### verilog/flash_program_erase_status.sv
// Program/erase status word generation, error stickiness and output latch
// What this block does
// - Status word latched at falling chip or output enable, held until enable rises.
// - During program/erase, reads in that bank return status unless read-array issued.
// - Ready, suspend and bank flags set and cleared by hardware from internal state.
// - Error flags stick until clear-status command or hardware reset.
// - Bits seven to one are device wide; bit zero follows the addressed bank.
// - Ready reads zero while engine active, one when idle.
// - After suspend, ready stays zero until engine paused, then one.
// - Erase-suspended reads one while erase suspended awaiting resume.
// - Program-suspended reads one while program suspended awaiting resume.
// - Resume clears suspended flag; late suspend may let operation finish instead.
// - Erase-fail set when max erase pulses applied and verify still fails.
// - Program-fail set when max program pulses applied and verify still fails.
// - Programming one over zero sets program-fail only with fast-program voltage.
// - Supply sampled at op start; below lockout sets supply-fault, op skipped.
// - Program or erase on locked block with supply above lockout sets lock-violation and aborts.
// - Busy: bit zero zero if addressed bank busy, one if another; ready: zero.
// - Factory mode busy: bit zero zero means next word ok; ready and zero exits.
`timescale 1ns/100ps
`default_nettype none
module flash_program_erase_status
	import pe_status_pkg::*;
#(
	parameter int BANK_W = BANK_W_DEF,
	parameter int DATA_W = DATA_W_DEF
) (
	input  wire logic              ref_clk,
	input  wire logic              resetn,
	// Memory bus pins (asynchronous to ref_clk)
	input  wire logic              chip_enable_n,
	input  wire logic              output_enable_n,
	input  wire logic [BANK_W-1:0] read_bank,
	// Program supply comparators on the program_supply_pin
	input  wire logic              supply_below_lockout,
	input  wire logic              fast_program_voltage,
	// Command decoder strobes, one cycle each, same clock; factory_program_mode is a held level
	input  wire logic              cmd_start,
	input  wire logic              cmd_is_erase,
	input  wire logic [BANK_W-1:0] cmd_bank,
	input  wire logic              cmd_block_locked,
	input  wire logic              cmd_suspend,
	input  wire logic              cmd_resume,
	input  wire logic              cmd_clear_status,
	input  wire logic              cmd_read_array,
	input  wire logic              cmd_read_status,
	input  wire logic              factory_program_mode,
	// Array algorithm events, one cycle each, same clock
	input  wire logic              alg_done,
	input  wire logic              alg_paused,
	input  wire logic              alg_max_pulse_fail,
	input  wire logic              alg_one_over_zero,
	input  wire logic              alg_word_ready,
	// Outputs
	output var  logic [DATA_W-1:0] status_data,
	output var  logic              status_select,
	output var  logic              alg_go,
	output var  logic              alg_pause_req
);
	engine_state_t     eng_q;
	op_kind_t          op_q;
	logic [BANK_W-1:0] op_bank_q;
	logic              read_array_q;
	logic              ers_fail_q;
	logic              prg_fail_q;
	logic              supply_q;
	logic              lock_q;
	logic              ers_susp_q;
	logic              prg_susp_q;
	logic              word_busy_q;
	logic              held_q;
	logic              start_ok;
	logic              start_bad_supply;
	logic              start_bad_lock;
	logic              ready;
	logic              bank0;
	logic [7:0]        live_word;

	logic [BANK_W+1:0] pins_sync;
	logic              ce_n_s;
	logic              oe_n_s;
	logic [BANK_W-1:0] bank_s;
	logic              enable_s;
	logic              enable_prev_q;
	logic [1:0]        supply_sync;
	logic              below_lockout_s;
	logic              fast_voltage_s;

	pin_sync #(
		.WIDTH(BANK_W + 2)
	) u_pin_sync (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.async_in({chip_enable_n, output_enable_n, read_bank}),
		.sync_out(pins_sync)
	);

	assign ce_n_s   = pins_sync[BANK_W+1];
	assign oe_n_s   = pins_sync[BANK_W];
	assign bank_s   = pins_sync[BANK_W-1:0];
	assign enable_s = !ce_n_s && !oe_n_s;

	// Supply comparators are analogue levels, not ref_clk logic
	pin_sync #(
		.WIDTH(2)
	) u_supply_sync (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.async_in({supply_below_lockout, fast_program_voltage}),
		.sync_out(supply_sync)
	);

	assign below_lockout_s = supply_sync[1];
	assign fast_voltage_s  = supply_sync[0];

	// Supply sampled only here, at the start of the operation
	assign start_bad_supply = cmd_start && (eng_q == ENG_IDLE) && below_lockout_s;
	assign start_bad_lock   = cmd_start && (eng_q == ENG_IDLE) && !below_lockout_s
		&& cmd_block_locked;
	assign start_ok = cmd_start && (eng_q == ENG_IDLE) && !below_lockout_s
		&& !cmd_block_locked;

	// Engine state: busy, pause handshake, suspended
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			eng_q <= ENG_IDLE;
		end else begin
			case (eng_q)
				ENG_IDLE: begin
					if (start_ok) begin
						eng_q <= ENG_RUN;
					end
				end
				ENG_RUN: begin
					if (alg_done) begin
						eng_q <= ENG_IDLE;
					end else if (cmd_suspend) begin
						eng_q <= ENG_SUSP_WAIT;
					end
				end
				ENG_SUSP_WAIT: begin
					// Finishing wins over pausing near the end
					if (alg_done) begin
						eng_q <= ENG_IDLE;
					end else if (alg_paused) begin
						eng_q <= ENG_SUSPENDED;
					end
				end
				ENG_SUSPENDED: begin
					if (cmd_resume) begin
						eng_q <= ENG_RUN;
					end
				end
				default: begin
					eng_q <= ENG_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			op_q <= OP_NONE;
		end else if (start_ok) begin
			op_q <= cmd_is_erase ? OP_ERASE : OP_PROGRAM;
		end else if (eng_q != ENG_IDLE && alg_done) begin
			op_q <= OP_NONE;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			op_bank_q <= '0;
		end else if (start_ok) begin
			op_bank_q <= cmd_bank;
		end
	end

	// Suspended flags follow the engine autonomously
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ers_susp_q <= 1'b0;
		end else if (eng_q == ENG_SUSP_WAIT && alg_paused && !alg_done) begin
			ers_susp_q <= (op_q == OP_ERASE);
		end else if (eng_q == ENG_SUSPENDED && cmd_resume) begin
			ers_susp_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			prg_susp_q <= 1'b0;
		end else if (eng_q == ENG_SUSP_WAIT && alg_paused && !alg_done) begin
			prg_susp_q <= (op_q == OP_PROGRAM);
		end else if (eng_q == ENG_SUSPENDED && cmd_resume) begin
			prg_susp_q <= 1'b0;
		end
	end

	// Sticky errors; a new event in the clearing cycle wins
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ers_fail_q <= 1'b0;
		end else if (eng_q != ENG_IDLE && alg_max_pulse_fail && op_q == OP_ERASE) begin
			ers_fail_q <= 1'b1;
		end else if (cmd_clear_status) begin
			ers_fail_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			prg_fail_q <= 1'b0;
		end else if (eng_q != ENG_IDLE && alg_max_pulse_fail && op_q == OP_PROGRAM) begin
			prg_fail_q <= 1'b1;
		end else if (eng_q != ENG_IDLE && op_q == OP_PROGRAM && alg_one_over_zero
			&& fast_voltage_s) begin
			prg_fail_q <= 1'b1;
		end else if (cmd_clear_status) begin
			prg_fail_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			supply_q <= 1'b0;
		end else if (start_bad_supply) begin
			supply_q <= 1'b1;
		end else if (cmd_clear_status) begin
			supply_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			lock_q <= 1'b0;
		end else if (start_bad_lock) begin
			lock_q <= 1'b1;
		end else if (cmd_clear_status) begin
			lock_q <= 1'b0;
		end
	end

	// Factory mode word handshake: busy from word accepted until ready
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			word_busy_q <= 1'b0;
		end else if (!factory_program_mode || alg_word_ready) begin
			word_busy_q <= 1'b0;
		end else if (start_ok) begin
			word_busy_q <= 1'b1;
		end
	end

	// Read-array since the start releases status mode in the busy bank
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			read_array_q <= 1'b0;
		end else if (start_ok || cmd_read_status) begin
			read_array_q <= 1'b0;
		end else if (cmd_read_array) begin
			read_array_q <= 1'b1;
		end
	end

	assign ready = (eng_q == ENG_IDLE) || (eng_q == ENG_SUSPENDED);

	always_comb begin
		if (ready) begin
			bank0 = 1'b0;
		end else if (factory_program_mode) begin
			bank0 = word_busy_q;
		end else begin
			bank0 = (bank_s != op_bank_q);
		end
	end

	always_comb begin
		live_word               = '0;
		live_word[BIT_READY]    = ready;
		live_word[BIT_ERS_SUSP] = ers_susp_q;
		live_word[BIT_ERS_FAIL] = ers_fail_q;
		live_word[BIT_PRG_FAIL] = prg_fail_q;
		live_word[BIT_SUPPLY]   = supply_q;
		live_word[BIT_PRG_SUSP] = prg_susp_q;
		live_word[BIT_LOCK]     = lock_q;
		live_word[BIT_BANK]     = bank0;
	end

	// Synchroniser resets to enabled; start as enabled so no false capture
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			enable_prev_q <= 1'b1;
			held_q        <= 1'b1;
		end else begin
			enable_prev_q <= enable_s;
			held_q        <= enable_s;
		end
	end

	// Output latch: captured at enable fall, frozen while enabled
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			status_data <= {{(DATA_W-STATUS_W){1'b0}}, STATUS_RESET};
		end else if (enable_s && !enable_prev_q) begin
			// Upper lines low so wide buses read a clean byte
			status_data <= {{(DATA_W-STATUS_W){1'b0}}, live_word};
		end else if (!enable_s && !held_q) begin
			status_data <= {{(DATA_W-STATUS_W){1'b0}}, live_word};
		end
	end

	// Status mode while busy in the addressed bank; read-array lifts it
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			status_select <= 1'b0;
		end else begin
			status_select <= (eng_q != ENG_IDLE) && (bank_s == op_bank_q)
				&& !read_array_q;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			alg_go <= 1'b0;
		end else begin
			alg_go <= start_ok || (eng_q == ENG_SUSPENDED && cmd_resume);
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			alg_pause_req <= 1'b0;
		end else begin
			alg_pause_req <= (eng_q == ENG_SUSP_WAIT);
		end
	end
endmodule
`default_nettype wire

// ### tb/flash_program_erase_status_props.sv
// Assertion checker for the status word block
`timescale 1ns/100ps
`default_nettype none
module flash_program_erase_status_props #(
	parameter int DATA_W = 16
) (
	input wire logic              ref_clk,
	input wire logic              resetn,
	input wire logic              chip_enable_n,
	input wire logic              cmd_start,
	input wire logic              cmd_block_locked,
	input wire logic              supply_below_lockout,
	input wire logic              cmd_clear_status,
	input wire logic              cmd_resume,
	input wire logic              alg_paused,
	input wire logic              alg_pause_req,
	input wire logic              alg_go,
	input wire logic [DATA_W-1:0] status_data
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// Word only tracks live state while no read has it frozen
	sequence s_quiet;
		chip_enable_n [*5];
	endsequence
	sequence s_susp;
		status_data[7] && (status_data[6] || status_data[2]);
	endsequence
	property p_sticky(int b);
		s_quiet ##0 $fell(status_data[b]) |-> $past(cmd_clear_status, 2) || $past(cmd_clear_status, 3);
	endproperty
	a_upper_zero: assert property (status_data[DATA_W-1:8] == '0) else $error("upper lines driven");
	a_go_busy: assert property (s_quiet ##0 alg_go |=> !status_data[7]) else $error("ready during run");
	a_lock_abort: assert property (cmd_start && cmd_block_locked |=> !alg_go [*2]) else $error("locked start ran");
	a_supply_abort: assert property (cmd_start && $past(supply_below_lockout, 2) |=> !alg_go [*2]) else $error("low supply ran");
	a_lock_sticky: assert property (p_sticky(1)) else $error("lock flag dropped");
	a_supply_sticky: assert property (p_sticky(3)) else $error("supply flag dropped");
	a_pause_wait: assert property (s_quiet ##0 alg_pause_req |-> !status_data[7]) else $error("ready before pause");
	a_paused_ready: assert property (s_quiet ##0 alg_pause_req && alg_paused |-> ##[2:3] s_susp) else $error("no suspend shown");
	a_resume_clears: assert property (s_quiet ##0 cmd_resume ##0 s_susp |-> ##[1:2] (alg_go ##1 !status_data[6] && !status_data[2])) else $error("resume failed");
	a_ready_bank: assert property (status_data[7] |-> !status_data[0]) else $error("bit zero set when ready");
endmodule
bind flash_program_erase_status flash_program_erase_status_props #(
	.DATA_W(DATA_W)
) flash_program_erase_status_props_inst (
	.ref_clk             (ref_clk),
	.resetn              (resetn),
	.chip_enable_n       (chip_enable_n),
	.cmd_start           (cmd_start),
	.cmd_block_locked    (cmd_block_locked),
	.supply_below_lockout(supply_below_lockout),
	.cmd_clear_status    (cmd_clear_status),
	.cmd_resume          (cmd_resume),
	.alg_paused          (alg_paused),
	.alg_pause_req       (alg_pause_req),
	.alg_go              (alg_go),
	.status_data         (status_data)
);
`default_nettype wire

// ### tb/alg_partner.sv
// Behavioural array algorithm answering start, resume and pause
`timescale 1ns/100ps
`default_nettype none
module alg_partner (
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	input  wire logic       alg_go,
	input  wire logic       alg_pause_req,
	input  wire logic [3:0] alg_latency,
	output var  logic       alg_done,
	output var  logic       alg_paused
);
	logic [3:0] cnt_q;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			{cnt_q, alg_done, alg_paused} <= '0;
		end else begin
			alg_paused <= 1'b0;
			alg_done <= 1'b0;
			if (alg_go) begin
				cnt_q <= alg_latency;
			end else if (cnt_q != 4'h0) begin
				// Too near the end to pause, so finish instead
				if (alg_pause_req && cnt_q > 4'h2) begin
					alg_paused <= 1'b1;
					cnt_q <= 4'h0;
				end else begin
					cnt_q <= cnt_q - 4'h1;
					alg_done <= (cnt_q == 4'h1);
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### tb/flash_program_erase_status_tb_top.sv
// Self-checking bench for the status word block
`timescale 1ns/100ps
`default_nettype none
module flash_program_erase_status_tb_top;
	logic ref_clk, resetn, chip_enable_n, output_enable_n, supply_below_lockout;
	logic fast_program_voltage, cmd_is_erase, cmd_block_locked, factory_program_mode;
	logic cmd_start, cmd_suspend, cmd_resume, cmd_clear_status, cmd_read_array;
	logic cmd_read_status, alg_max_pulse_fail, alg_one_over_zero, alg_word_ready;
	logic alg_done, alg_paused, alg_go, alg_pause_req, status_select;
	logic [3:0] read_bank, cmd_bank, alg_latency;
	logic [15:0] status_data;
	logic [8:0] p;
	logic [7:0] rnd;
	logic [15:0] ef [4] = '{16'h00a0, 16'h0090, 16'h0090, 16'h0080};
	int err_count, checks_done;
	assign {alg_word_ready, alg_one_over_zero, alg_max_pulse_fail, cmd_read_status,
		cmd_read_array, cmd_clear_status, cmd_resume, cmd_suspend, cmd_start} = p;
	flash_program_erase_status flash_program_erase_status_inst (
		.ref_clk             (ref_clk),
		.resetn              (resetn),
		.chip_enable_n       (chip_enable_n),
		.output_enable_n     (output_enable_n),
		.read_bank           (read_bank),
		.supply_below_lockout(supply_below_lockout),
		.fast_program_voltage(fast_program_voltage),
		.cmd_start           (cmd_start),
		.cmd_is_erase        (cmd_is_erase),
		.cmd_bank            (cmd_bank),
		.cmd_block_locked    (cmd_block_locked),
		.cmd_suspend         (cmd_suspend),
		.cmd_resume          (cmd_resume),
		.cmd_clear_status    (cmd_clear_status),
		.cmd_read_array      (cmd_read_array),
		.cmd_read_status     (cmd_read_status),
		.factory_program_mode(factory_program_mode),
		.alg_done            (alg_done),
		.alg_paused          (alg_paused),
		.alg_max_pulse_fail  (alg_max_pulse_fail),
		.alg_one_over_zero   (alg_one_over_zero),
		.alg_word_ready      (alg_word_ready),
		.status_data         (status_data),
		.status_select       (status_select),
		.alg_go              (alg_go),
		.alg_pause_req       (alg_pause_req)
	);
	alg_partner alg_partner_inst (
		.ref_clk      (ref_clk),
		.resetn       (resetn),
		.alg_go       (alg_go),
		.alg_pause_req(alg_pause_req),
		.alg_latency  (alg_latency),
		.alg_done     (alg_done),
		.alg_paused   (alg_paused)
	);
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	function automatic logic [7:0] nxt(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task pulse(input int i);
		p[i] = 1'b1;
		cyc(1);
		p = '0;
	endtask
	task op(input logic e, input logic [3:0] b);
		cmd_is_erase = e;
		cmd_bank = b;
		pulse(0);
		cyc(4);
	endtask
	task chk(input string what, input logic [15:0] exp, got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task idle(input logic [15:0] e);
		for (int k = 0; k < 64 && status_data[7] !== 1'b1; k++)
			cyc(1);
		cyc(1);
		chk("idle word", e, status_data);
	endtask
	task results;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		// Generous bound; the whole sequence needs well under a thousand cycles
		repeat (4000) @(posedge ref_clk);
		err_count++;
		results;
	end
	initial begin
		{resetn, chip_enable_n, output_enable_n, p, rnd} = {3'b011, 9'h000, 8'h32};
		{supply_below_lockout, fast_program_voltage, cmd_block_locked} = 3'b000;
		{factory_program_mode, cmd_is_erase, cmd_bank, read_bank} = '0;
		{err_count, checks_done, alg_latency} = {32'h0, 32'h0, 4'hf};
		cyc(2);
		resetn = 1'b1;
		cyc(1);
		chk("reset word", 16'h0080, status_data);
		for (int i = 0; i < 6; i++) begin
			rnd = nxt(rnd);
			alg_latency = {2'b11, rnd[1:0]};
			read_bank = (i < 2) ? rnd[7:4] : rnd[3:0];
			op(i[0], rnd[7:4]);
			supply_below_lockout = 1'b1;
			chk("busy word", {15'h0000, read_bank != cmd_bank}, status_data);
			chk("select", {15'h0000, read_bank == cmd_bank}, {15'h0000, status_select});
			pulse(4);
			cyc(2);
			chk("read array", 16'h0000, {15'h0000, status_select});
			pulse(5);
			idle(16'h0080);
			supply_below_lockout = 1'b0;
			cyc(3);
			$display("test busy %0d done", i);
		end
		for (int j = 0; j < 4; j++) begin
			fast_program_voltage = (j == 2);
			op(j == 0, 4'h1);
			pulse(j < 2 ? 6 : 7);
			idle(ef[j]);
			cyc(8);
			chk("sticky", ef[j], status_data);
			pulse(3);
			cyc(3);
			chk("cleared", 16'h0080, status_data);
		end
		for (int j = 0; j < 2; j++) begin
			{supply_below_lockout, cmd_block_locked} = j ? 2'b01 : 2'b10;
			cyc(3);
			op(1'b0, 4'h2);
			chk("abort", j ? 16'h0082 : 16'h0088, status_data);
			pulse(3);
			cyc(3);
		end
		{supply_below_lockout, cmd_block_locked, read_bank} = 6'h03;
		$display("test errors done");
		for (int j = 0; j < 3; j++) begin
			alg_latency = (j == 2) ? 4'h7 : 4'hf;
			op(j == 0, 4'h3);
			pulse(1);
			idle(j == 0 ? 16'h00c0 : j == 1 ? 16'h0084 : 16'h0080);
			if (j < 2) begin
				pulse(2);
				cyc(4);
				chk("resumed", 16'h0000, status_data);
				idle(16'h0080);
			end
		end
		$display("test suspend done");
		{alg_latency, factory_program_mode} = 5'h1f;
		op(1'b0, 4'h5);
		chk("word busy", 16'h0001, status_data);
		pulse(8);
		cyc(3);
		chk("word ready", 16'h0000, status_data);
		idle(16'h0080);
		{factory_program_mode, read_bank, chip_enable_n, output_enable_n} = 7'h00;
		cyc(5);
		op(1'b0, 4'h0);
		chk("latched", 16'h0080, status_data);
		chip_enable_n = 1'b1;
		cyc(5);
		chk("released", 16'h0000, status_data);
		output_enable_n = 1'b1;
		idle(16'h0080);
		$display("test factory and latch done");
		results;
	end
endmodule
`default_nettype wire
